/* File: hw/guest_access_pkg.sv */
package guest_access_pkg;

    // Privilege encodings of the hart.
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_SUPER = 2'h1;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;

    // Operation codes presented by the front end.
    localparam logic [3:0] OP_NONE = 4'h0;
    localparam logic [3:0] OP_LOAD_B = 4'h1;
    localparam logic [3:0] OP_LOAD_BU = 4'h2;
    localparam logic [3:0] OP_LOAD_H = 4'h3;
    localparam logic [3:0] OP_LOAD_HU = 4'h4;
    localparam logic [3:0] OP_LOAD_W = 4'h5;
    localparam logic [3:0] OP_LOAD_WU = 4'h6;
    localparam logic [3:0] OP_LOAD_D = 4'h7;
    localparam logic [3:0] OP_EXEC_HU = 4'h8;
    localparam logic [3:0] OP_EXEC_WU = 4'h9;
    localparam logic [3:0] OP_STORE_B = 4'hA;
    localparam logic [3:0] OP_STORE_H = 4'hB;
    localparam logic [3:0] OP_STORE_W = 4'hC;
    localparam logic [3:0] OP_STORE_D = 4'hD;
    localparam logic [3:0] OP_FENCE_S1 = 4'hE;
    localparam logic [3:0] OP_FENCE_S2 = 4'hF;

    // Access size codes: byte, half, word, double.
    localparam logic [1:0] SIZE_B = 2'h0;
    localparam logic [1:0] SIZE_H = 2'h1;
    localparam logic [1:0] SIZE_W = 2'h2;
    localparam logic [1:0] SIZE_D = 2'h3;

    // Trap kinds.
    localparam logic [1:0] TRAP_NONE = 2'h0;
    localparam logic [1:0] TRAP_ILLEGAL = 2'h1;
    localparam logic [1:0] TRAP_VIRTUAL = 2'h2;

    // Fence scope codes.
    localparam logic [1:0] SCOPE_ALL = 2'h0;
    localparam logic [1:0] SCOPE_ID = 2'h1;
    localparam logic [1:0] SCOPE_ADDR = 2'h2;
    localparam logic [1:0] SCOPE_ADDR_ID = 2'h3;

    // Guest physical fence address is given shifted right by this amount.
    localparam int GPA_SHIFT = 2;

    localparam int XLEN_32 = 32;
    localparam int XLEN_64 = 64;
    localparam int MAX_SPACE_ID_WIDTH_32 = 9;
    localparam int MAX_SPACE_ID_WIDTH_64 = 16;
    localparam int MAX_VM_ID_WIDTH_32 = 7;
    localparam int MAX_VM_ID_WIDTH_64 = 14;

endpackage

/* File: hw/guest_access_decode.sv */
// How it works
// - Guest loads/stores allowed in machine, hypervisor-supervisor, or user with enable set.
// - Guest accesses translate and protect as if virtualization were on.
// - Privilege select 0 gives guest user access, 1 gives guest supervisor.
// - Guest accesses always two-stage; hypervisor supervisor-user-access bit ignored, guest copy used.
// - Hypervisor exec-readable bit hits both stages; guest copy first stage only.
// - All widths provided; unsigned word and doubleword rejected on 32-bit harts.
// - Exec-loads need execute, not read, in both stages; final attributes need both.
// - Exec-load to execute-only protected memory still takes an access fault.
// - Unsigned-word exec-load is accepted on 32-bit harts.
// - Guest access traps virtual when virtualized, illegal in user without enable.
// - Stage-one fence legal in machine or hypervisor mode; acts as guest fence.
// - Stage-one fence orders stores for reads under the same machine identifier.
// - Stage-one fence: nonzero source one picks an address, two a space id.
// - Space id bits above implemented width are ignored.
// - Stage-one fence filters may be dropped for a global fence.
// - Translation-management trap bits never trap the stage-one fence.
// - Stage-two fence legal in machine, or hypervisor mode with trap bit clear.
// - Stage-two fence: source one is guest physical address >> 2, two a VM id.
// - Stage-two fence flushes matching second-stage or combined entries.
// - Machine id bits above implemented width are ignored.
// - Fences trap virtual when virtualized, illegal in user; stage-two also on trap bit.
`timescale 1ns/10ps

module guest_access_decode #(
    parameter int XLEN = 64,
    parameter int SPACE_ID_LEN = 16,
    parameter int VM_ID_LEN = 14,
    parameter bit GLOBAL_STAGE1_FENCE = 1'b0,
    parameter bit GLOBAL_STAGE2_FENCE = 1'b0
)(
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic OP_VALID,
    input wire logic [3:0] OP_CODE,
    input wire logic SRC1_IS_ZERO,
    input wire logic SRC2_IS_ZERO,
    input wire logic [XLEN-1:0] SRC1_VALUE,
    input wire logic [XLEN-1:0] SRC2_VALUE,
    input wire logic [1:0] PRIV_MODE,
    input wire logic VIRT_MODE,
    input wire logic USER_GUEST_ACCESS_ENABLE,
    input wire logic GUEST_ACCESS_PRIV_SELECT,
    input wire logic TRAP_TRANSLATION_MGMT,
    input wire logic VIRTUAL_TRAP_TRANSLATION_MGMT,
    input wire logic HS_MAKE_EXEC_READABLE,
    input wire logic VS_MAKE_EXEC_READABLE,
    input wire logic HS_SUPERVISOR_USER_ACCESS,
    input wire logic VS_SUPERVISOR_USER_ACCESS,
    input wire logic [VM_ID_LEN-1:0] CURRENT_VM_ID,
    input wire logic PMP_EXEC_ONLY,
    output logic TRAP_VALID,
    output logic [1:0] TRAP_KIND,
    output logic ACCESS_FAULT,
    output logic MEM_VALID,
    output logic MEM_WRITE,
    output logic [1:0] MEM_SIZE,
    output logic MEM_UNSIGNED,
    output logic [XLEN-1:0] MEM_ADDR,
    output logic MEM_VIRT,
    output logic MEM_GUEST_SUPER,
    output logic MEM_TWO_STAGE,
    output logic MEM_SUPERVISOR_USER_ACCESS,
    output logic MEM_STAGE1_EXEC_READABLE,
    output logic MEM_STAGE2_EXEC_READABLE,
    output logic MEM_NEED_EXEC,
    output logic MEM_FINAL_NEED_EXEC_READ,
    output logic FENCE1_VALID,
    output logic [1:0] FENCE1_SCOPE,
    output logic FENCE1_ALL_GUESTS,
    output logic [XLEN-1:0] FENCE1_ADDR,
    output logic [SPACE_ID_LEN-1:0] FENCE1_SPACE_ID,
    output logic [VM_ID_LEN-1:0] FENCE1_VM_ID,
    output logic FENCE2_VALID,
    output logic [1:0] FENCE2_SCOPE,
    output logic [XLEN+1:0] FENCE2_GPA,
    output logic [VM_ID_LEN-1:0] FENCE2_VM_ID
);

    localparam int MAX_SPACE = (XLEN == guest_access_pkg::XLEN_32)
        ? guest_access_pkg::MAX_SPACE_ID_WIDTH_32
        : guest_access_pkg::MAX_SPACE_ID_WIDTH_64;
    localparam int MAX_VM = (XLEN == guest_access_pkg::XLEN_32)
        ? guest_access_pkg::MAX_VM_ID_WIDTH_32
        : guest_access_pkg::MAX_VM_ID_WIDTH_64;

    // Refuse widths that the identifier slices or the hart cannot serve.
    // Identifier widths may be narrower than the maximum, never wider.
    initial
    begin
        if (XLEN != guest_access_pkg::XLEN_32 &&
            XLEN != guest_access_pkg::XLEN_64)
        begin
            $error("XLEN must be 32 or 64.");
        end
        if (SPACE_ID_LEN < 1 || SPACE_ID_LEN > MAX_SPACE)
        begin
            $error("SPACE_ID_LEN out of range.");
        end
        if (VM_ID_LEN < 1 || VM_ID_LEN > MAX_VM)
        begin
            $error("VM_ID_LEN out of range.");
        end
    end

    // All outputs live in this one register so each comes from a flip-flop.
    // Fields not used by the current answer stay zero.
    typedef struct packed {
        logic trap_valid;
        logic [1:0] trap_kind;
        logic access_fault;
        logic mem_valid;
        logic mem_write;
        logic [1:0] mem_size;
        logic mem_unsigned;
        logic [XLEN-1:0] mem_addr;
        logic mem_virt;
        logic mem_guest_super;
        logic mem_two_stage;
        logic mem_sum;
        logic mem_s1_mxr;
        logic mem_s2_mxr;
        logic mem_need_exec;
        logic mem_final_xr;
        logic f1_valid;
        logic [1:0] f1_scope;
        logic f1_all;
        logic [XLEN-1:0] f1_addr;
        logic [SPACE_ID_LEN-1:0] f1_space;
        logic [VM_ID_LEN-1:0] f1_vm;
        logic f2_valid;
        logic [1:0] f2_scope;
        logic [XLEN+1:0] f2_gpa;
        logic [VM_ID_LEN-1:0] f2_vm;
    } state_s;

    state_s state_reg;
    state_s state_next;

    logic is_load;
    logic is_exec;
    logic is_store;
    logic is_fence1;
    logic is_fence2;
    logic bad_width;
    logic priv_ok;
    logic [1:0] size;
    logic unsgn;

    always_comb
    begin
        is_load = OP_CODE >= guest_access_pkg::OP_LOAD_B &&
            OP_CODE <= guest_access_pkg::OP_LOAD_D;
        is_exec = OP_CODE == guest_access_pkg::OP_EXEC_HU ||
            OP_CODE == guest_access_pkg::OP_EXEC_WU;
        is_store = OP_CODE >= guest_access_pkg::OP_STORE_B &&
            OP_CODE <= guest_access_pkg::OP_STORE_D;
        is_fence1 = OP_CODE == guest_access_pkg::OP_FENCE_S1;
        is_fence2 = OP_CODE == guest_access_pkg::OP_FENCE_S2;
        size = guest_access_pkg::SIZE_B;
        unsgn = 1'b0;
        case (OP_CODE)
            guest_access_pkg::OP_LOAD_BU:
            begin
                unsgn = 1'b1;
            end
            guest_access_pkg::OP_LOAD_H,
            guest_access_pkg::OP_STORE_H:
            begin
                size = guest_access_pkg::SIZE_H;
            end
            guest_access_pkg::OP_LOAD_HU,
            guest_access_pkg::OP_EXEC_HU:
            begin
                size = guest_access_pkg::SIZE_H;
                unsgn = 1'b1;
            end
            guest_access_pkg::OP_LOAD_W,
            guest_access_pkg::OP_STORE_W:
            begin
                size = guest_access_pkg::SIZE_W;
            end
            guest_access_pkg::OP_LOAD_WU,
            guest_access_pkg::OP_EXEC_WU:
            begin
                size = guest_access_pkg::SIZE_W;
                unsgn = 1'b1;
            end
            guest_access_pkg::OP_LOAD_D,
            guest_access_pkg::OP_STORE_D:
            begin
                size = guest_access_pkg::SIZE_D;
            end
            default:
            begin
                size = guest_access_pkg::SIZE_B;
            end
        endcase
        // On a 32-bit hart the exec-load word is a plain word access.
        bad_width = 1'b0;
        if (XLEN == guest_access_pkg::XLEN_32)
        begin
            bad_width = OP_CODE == guest_access_pkg::OP_LOAD_WU ||
                OP_CODE == guest_access_pkg::OP_LOAD_D ||
                OP_CODE == guest_access_pkg::OP_STORE_D;
            if (OP_CODE == guest_access_pkg::OP_EXEC_WU)
            begin
                unsgn = 1'b0;
            end
        end
        priv_ok = 1'b0;
        if (is_load || is_exec || is_store)
        begin
            priv_ok = PRIV_MODE == guest_access_pkg::PRIV_MACHINE ||
                PRIV_MODE == guest_access_pkg::PRIV_SUPER ||
                (PRIV_MODE == guest_access_pkg::PRIV_USER &&
                USER_GUEST_ACCESS_ENABLE);
        end
        else if (is_fence1)
        begin
            // Neither trap bit is read here, so neither can refuse this fence.
            priv_ok = PRIV_MODE == guest_access_pkg::PRIV_MACHINE ||
                PRIV_MODE == guest_access_pkg::PRIV_SUPER;
        end
        else if (is_fence2)
        begin
            priv_ok = PRIV_MODE == guest_access_pkg::PRIV_MACHINE ||
                (PRIV_MODE == guest_access_pkg::PRIV_SUPER &&
                !TRAP_TRANSLATION_MGMT);
        end
    end

    always_comb
    begin
        state_next = '0;
        // A virtualized attempt takes the virtual trap before any privilege
        // or width check, so the hypervisor can emulate the instruction.
        if (OP_VALID && OP_CODE != guest_access_pkg::OP_NONE)
        begin
            if (VIRT_MODE)
            begin
                state_next.trap_valid = 1'b1;
                state_next.trap_kind = guest_access_pkg::TRAP_VIRTUAL;
            end
            else if (!priv_ok || bad_width)
            begin
                state_next.trap_valid = 1'b1;
                state_next.trap_kind = guest_access_pkg::TRAP_ILLEGAL;
            end
            else if (is_load || is_exec || is_store)
            begin
                state_next.mem_valid = 1'b1;
                state_next.mem_write = is_store;
                state_next.mem_size = size;
                state_next.mem_unsigned = unsgn;
                state_next.mem_addr = SRC1_VALUE;
                state_next.mem_virt = 1'b1;
                state_next.mem_guest_super = GUEST_ACCESS_PRIV_SELECT;
                state_next.mem_two_stage = 1'b1;
                // Only the guest copy of the user-access bit is honoured.
                state_next.mem_sum = VS_SUPERVISOR_USER_ACCESS;
                state_next.mem_s1_mxr = HS_MAKE_EXEC_READABLE ||
                    VS_MAKE_EXEC_READABLE;
                state_next.mem_s2_mxr = HS_MAKE_EXEC_READABLE;
                state_next.mem_need_exec = is_exec;
                state_next.mem_final_xr = is_exec;
                state_next.access_fault = is_exec && PMP_EXEC_ONLY;
            end
            else if (is_fence1)
            begin
                state_next.f1_valid = 1'b1;
                state_next.f1_all = GLOBAL_STAGE1_FENCE;
                if (!GLOBAL_STAGE1_FENCE)
                begin
                    state_next.f1_scope = {!SRC1_IS_ZERO,
                        !SRC2_IS_ZERO};
                    state_next.f1_addr = SRC1_IS_ZERO ? '0 : SRC1_VALUE;
                    state_next.f1_space = SRC2_IS_ZERO ? '0 :
                        SRC2_VALUE[SPACE_ID_LEN-1:0];
                    state_next.f1_vm = CURRENT_VM_ID;
                end
            end
            else
            begin
                // The address comes shifted right by two, so it is widened
                // back here to reach beyond the register width.
                state_next.f2_valid = 1'b1;
                if (!GLOBAL_STAGE2_FENCE)
                begin
                    state_next.f2_scope = {!SRC1_IS_ZERO,
                        !SRC2_IS_ZERO};
                    state_next.f2_gpa = SRC1_IS_ZERO ? '0 :
                        {SRC1_VALUE, {guest_access_pkg::GPA_SHIFT{1'b0}}};
                    state_next.f2_vm = SRC2_IS_ZERO ? '0 :
                        SRC2_VALUE[VM_ID_LEN-1:0];
                end
            end
        end
    end

    // Every answer stands for exactly one cycle after the request edge.
    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign TRAP_VALID = state_reg.trap_valid;
    assign TRAP_KIND = state_reg.trap_kind;
    assign ACCESS_FAULT = state_reg.access_fault;
    assign MEM_VALID = state_reg.mem_valid;
    assign MEM_WRITE = state_reg.mem_write;
    assign MEM_SIZE = state_reg.mem_size;
    assign MEM_UNSIGNED = state_reg.mem_unsigned;
    assign MEM_ADDR = state_reg.mem_addr;
    assign MEM_VIRT = state_reg.mem_virt;
    assign MEM_GUEST_SUPER = state_reg.mem_guest_super;
    assign MEM_TWO_STAGE = state_reg.mem_two_stage;
    assign MEM_SUPERVISOR_USER_ACCESS = state_reg.mem_sum;
    assign MEM_STAGE1_EXEC_READABLE = state_reg.mem_s1_mxr;
    assign MEM_STAGE2_EXEC_READABLE = state_reg.mem_s2_mxr;
    assign MEM_NEED_EXEC = state_reg.mem_need_exec;
    assign MEM_FINAL_NEED_EXEC_READ = state_reg.mem_final_xr;
    assign FENCE1_VALID = state_reg.f1_valid;
    assign FENCE1_SCOPE = state_reg.f1_scope;
    assign FENCE1_ALL_GUESTS = state_reg.f1_all;
    assign FENCE1_ADDR = state_reg.f1_addr;
    assign FENCE1_SPACE_ID = state_reg.f1_space;
    assign FENCE1_VM_ID = state_reg.f1_vm;
    assign FENCE2_VALID = state_reg.f2_valid;
    assign FENCE2_SCOPE = state_reg.f2_scope;
    assign FENCE2_GPA = state_reg.f2_gpa;
    assign FENCE2_VM_ID = state_reg.f2_vm;

endmodule

/* File: testbench/guest_access_chk.sv */
`timescale 1ns/10ps
module guest_access_chk #(
    parameter int XLEN = 64,
    parameter int VM_ID_LEN = 14
)(
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic OP_VALID,
    input wire logic [3:0] OP_CODE,
    input wire logic SRC2_IS_ZERO,
    input wire logic [XLEN-1:0] SRC2_VALUE,
    input wire logic [1:0] PRIV_MODE,
    input wire logic VIRT_MODE,
    input wire logic USER_GUEST_ACCESS_ENABLE,
    input wire logic GUEST_ACCESS_PRIV_SELECT,
    input wire logic TRAP_TRANSLATION_MGMT,
    input wire logic HS_MAKE_EXEC_READABLE,
    input wire logic VS_MAKE_EXEC_READABLE,
    input wire logic PMP_EXEC_ONLY,
    input wire logic TRAP_VALID,
    input wire logic [1:0] TRAP_KIND,
    input wire logic ACCESS_FAULT,
    input wire logic MEM_VALID,
    input wire logic MEM_VIRT,
    input wire logic MEM_GUEST_SUPER,
    input wire logic MEM_TWO_STAGE,
    input wire logic MEM_STAGE1_EXEC_READABLE,
    input wire logic MEM_STAGE2_EXEC_READABLE,
    input wire logic FENCE1_VALID,
    input wire logic FENCE2_VALID,
    input wire logic [VM_ID_LEN-1:0] FENCE2_VM_ID
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    logic take;
    logic hs;
    assign take = OP_VALID && OP_CODE != 4'h0;
    assign hs = !VIRT_MODE && PRIV_MODE == guest_access_pkg::PRIV_SUPER;

    a_virt_traps: assert property (take && VIRT_MODE |=> TRAP_VALID
        && TRAP_KIND == guest_access_pkg::TRAP_VIRTUAL) else $error("no virtual trap");
    a_user_no_enable: assert property (take && !VIRT_MODE && PRIV_MODE == 2'h0
        && !USER_GUEST_ACCESS_ENABLE |=> TRAP_VALID && TRAP_KIND == 2'h1)
        else $error("user access did not trap illegal");
    a_user_enabled: assert property (take && !VIRT_MODE && PRIV_MODE == 2'h0
        && USER_GUEST_ACCESS_ENABLE && OP_CODE inside {[4'h1:4'h5], [4'h8:4'hC]}
        |=> MEM_VALID && !TRAP_VALID) else $error("enabled user access refused");
    a_guest_context: assert property (MEM_VALID |-> MEM_VIRT && MEM_TWO_STAGE)
        else $error("guest access context wrong");
    a_priv_select: assert property (MEM_VALID
        |-> MEM_GUEST_SUPER == $past(GUEST_ACCESS_PRIV_SELECT))
        else $error("guest privilege wrong");
    a_exec_readable: assert property (MEM_VALID
        |-> MEM_STAGE2_EXEC_READABLE == $past(HS_MAKE_EXEC_READABLE)
        && MEM_STAGE1_EXEC_READABLE == ($past(HS_MAKE_EXEC_READABLE)
        || $past(VS_MAKE_EXEC_READABLE))) else $error("exec readable wrong");
    a_exec_fault: assert property (take && OP_CODE inside {4'h8, 4'h9}
        && PMP_EXEC_ONLY && !VIRT_MODE && PRIV_MODE == 2'h3 |=> ACCESS_FAULT)
        else $error("exec-only fault missing");
    a_fence1_no_trap: assert property (take && OP_CODE == 4'hE
        && !VIRT_MODE && PRIV_MODE != 2'h0 |=> FENCE1_VALID && !TRAP_VALID)
        else $error("stage one fence refused");
    a_fence2_tvm: assert property (take && OP_CODE == 4'hF && hs
        |=> TRAP_VALID == $past(TRAP_TRANSLATION_MGMT)
        && FENCE2_VALID == !TRAP_VALID)
        else $error("stage two fence legality wrong");
    a_wide_illegal: assert property (take && XLEN == 32 && !VIRT_MODE
        && OP_CODE inside {4'h6, 4'h7, 4'hD} |=> TRAP_VALID && TRAP_KIND == 2'h1)
        else $error("wide op accepted on narrow hart");
    a_vm_id_trunc: assert property (FENCE2_VALID && !$past(SRC2_IS_ZERO)
        |-> FENCE2_VM_ID == $past(SRC2_VALUE[VM_ID_LEN-1:0]))
        else $error("machine id not truncated");
    c_mem: cover property (MEM_VALID && ACCESS_FAULT);
    c_fence1: cover property (FENCE1_VALID);
    c_fence2: cover property (FENCE2_VALID);
endmodule

bind guest_access_decode guest_access_chk #(
    .XLEN(XLEN),
    .VM_ID_LEN(VM_ID_LEN)
) i_chk (.CLK_SYS, .RESETN, .OP_VALID, .OP_CODE, .SRC2_IS_ZERO, .SRC2_VALUE,
    .PRIV_MODE, .VIRT_MODE, .USER_GUEST_ACCESS_ENABLE, .GUEST_ACCESS_PRIV_SELECT,
    .TRAP_TRANSLATION_MGMT, .HS_MAKE_EXEC_READABLE, .VS_MAKE_EXEC_READABLE,
    .PMP_EXEC_ONLY, .TRAP_VALID, .TRAP_KIND, .ACCESS_FAULT, .MEM_VALID,
    .MEM_VIRT, .MEM_GUEST_SUPER, .MEM_TWO_STAGE, .MEM_STAGE1_EXEC_READABLE,
    .MEM_STAGE2_EXEC_READABLE, .FENCE1_VALID, .FENCE2_VALID, .FENCE2_VM_ID);

/* File: testbench/xlate_model.sv */
`timescale 1ns/10ps
module xlate_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic mem_valid,
    input wire logic fence1_valid,
    input wire logic fence2_valid,
    output int n_mem,
    output int n_fence
);
    // Counts the accesses and flushes that reach the translation side.
    always_ff @(posedge clk or negedge reset_n)
        if (!reset_n)
        begin
            n_mem <= 0;
            n_fence <= 0;
        end
        else
        begin
            n_mem <= n_mem + int'(mem_valid);
            n_fence <= n_fence + int'(fence1_valid) + int'(fence2_valid);
        end
endmodule

/* File: testbench/test_guest_access_decode.sv */
`timescale 1ns/10ps
module test_guest_access_decode;
    localparam int XL = 32;
    localparam int SL = 6;
    localparam int VL = 5;
    logic clk = 1'b0, reset_n = 1'b0, op_valid = 1'b0, s1z = 1'b0, s2z = 1'b0;
    logic virt = 1'b0, ugae = 1'b0, sel = 1'b0, trap_translation_mgmt = 1'b0, virtual_trap_translation_mgmt = 1'b0;
    logic hs_mxr = 1'b0, vs_mxr = 1'b0, hs_sua = 1'b0, vs_sua = 1'b0, pmp = 1'b0;
    logic [3:0] op_code = 4'h0;
    logic [1:0] priv = 2'h0;
    logic [XL-1:0] s1v = 32'h0, s2v = 32'h0;
    logic [VL-1:0] vmid = 5'h0;
    logic trap_v, fault, mem_v, mem_w, mem_uns, mem_virt, mem_gs, mem_two;
    logic mem_sua, mem_x1, mem_x2, need_x, fin_xr, f1_v, f1_all, f2_v;
    logic [1:0] trap_k, mem_size, f1_scope, f2_scope;
    logic [XL-1:0] mem_addr, f1_addr;
    logic [SL-1:0] f1_sid;
    logic [VL-1:0] f1_vmid, f2_vmid;
    logic [XL+1:0] f2_gpa;
    int failures = 0, n_compared = 0, n_mem, n_fence, exp_mem = 0, exp_fence = 0;

    guest_access_decode #(.XLEN(XL), .SPACE_ID_LEN(SL), .VM_ID_LEN(VL)) i_dut (
        .CLK_SYS(clk), .RESETN(reset_n), .OP_VALID(op_valid), .OP_CODE(op_code),
        .SRC1_IS_ZERO(s1z), .SRC2_IS_ZERO(s2z), .SRC1_VALUE(s1v),
        .SRC2_VALUE(s2v), .PRIV_MODE(priv), .VIRT_MODE(virt),
        .USER_GUEST_ACCESS_ENABLE(ugae), .GUEST_ACCESS_PRIV_SELECT(sel),
        .TRAP_TRANSLATION_MGMT(trap_translation_mgmt), .VIRTUAL_TRAP_TRANSLATION_MGMT(virtual_trap_translation_mgmt),
        .HS_MAKE_EXEC_READABLE(hs_mxr), .VS_MAKE_EXEC_READABLE(vs_mxr),
        .HS_SUPERVISOR_USER_ACCESS(hs_sua), .VS_SUPERVISOR_USER_ACCESS(vs_sua),
        .CURRENT_VM_ID(vmid), .PMP_EXEC_ONLY(pmp), .TRAP_VALID(trap_v),
        .TRAP_KIND(trap_k), .ACCESS_FAULT(fault), .MEM_VALID(mem_v),
        .MEM_WRITE(mem_w), .MEM_SIZE(mem_size), .MEM_UNSIGNED(mem_uns),
        .MEM_ADDR(mem_addr), .MEM_VIRT(mem_virt), .MEM_GUEST_SUPER(mem_gs),
        .MEM_TWO_STAGE(mem_two), .MEM_SUPERVISOR_USER_ACCESS(mem_sua),
        .MEM_STAGE1_EXEC_READABLE(mem_x1), .MEM_STAGE2_EXEC_READABLE(mem_x2),
        .MEM_NEED_EXEC(need_x), .MEM_FINAL_NEED_EXEC_READ(fin_xr),
        .FENCE1_VALID(f1_v), .FENCE1_SCOPE(f1_scope), .FENCE1_ALL_GUESTS(f1_all),
        .FENCE1_ADDR(f1_addr), .FENCE1_SPACE_ID(f1_sid), .FENCE1_VM_ID(f1_vmid),
        .FENCE2_VALID(f2_v), .FENCE2_SCOPE(f2_scope), .FENCE2_GPA(f2_gpa),
        .FENCE2_VM_ID(f2_vmid));
    xlate_model i_model (.clk(clk), .reset_n(reset_n), .mem_valid(mem_v),
        .fence1_valid(f1_v), .fence2_valid(f2_v), .n_mem(n_mem), .n_fence(n_fence));

    initial
        forever #5 clk = ~clk;

    task automatic check(input string what, input logic [39:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One operation: a single-cycle request, answer registered one edge later.
    task automatic issue(input logic [3:0] c);
        @(posedge clk);
        #1 op_valid = 1'b1;
        op_code = c;
        @(posedge clk);
        #1 op_valid = 1'b0;
    endtask

    function automatic logic [1:0] exp_kind(input logic [3:0] c);
        if (virt)
            return guest_access_pkg::TRAP_VIRTUAL;
        if (priv == guest_access_pkg::PRIV_USER && (c >= 4'hE || !ugae))
            return guest_access_pkg::TRAP_ILLEGAL;
        if (c == 4'hF && priv == guest_access_pkg::PRIV_SUPER && trap_translation_mgmt)
            return guest_access_pkg::TRAP_ILLEGAL;
        if (c == 4'h6 || c == 4'h7 || c == 4'hD)
            return guest_access_pkg::TRAP_ILLEGAL;
        return guest_access_pkg::TRAP_NONE;
    endfunction

    function automatic logic [1:0] exp_size(input logic [3:0] c);
        case (c)
            4'h1, 4'h2: return 2'h0;
            4'h3, 4'h4, 4'h8: return 2'h1;
            4'h5, 4'h6, 4'h9: return 2'h2;
            4'h7: return 2'h3;
            default: return 2'(c - 4'hA);
        endcase
    endfunction

    initial
    begin
        logic [3:0] c;
        logic [1:0] k;
        logic x, m;
        repeat (5) @(posedge clk);
        #1 reset_n = 1'b1;
        for (int i = 0; i < 360; i++)
        begin
            c = 4'(1 + i % 15);
            priv = (i / 15 % 3 == 2) ? 2'h3 : 2'(i / 15 % 3);
            virt = 1'(i / 45);
            ugae = 1'(i / 90);
            trap_translation_mgmt = 1'(i / 180);
            {sel, hs_mxr, vs_mxr, vs_sua, hs_sua} = {ugae ^ trap_translation_mgmt, trap_translation_mgmt, ugae, ugae, !ugae};
            {pmp, virtual_trap_translation_mgmt, s1z, s2z} = {ugae, !trap_translation_mgmt, trap_translation_mgmt, ugae};
            s1v = 32'hA5A50000 ^ 32'(i * 7);
            s2v = 32'hFFFFFF00 | 32'(i);
            vmid = 5'(i);
            issue(c);
            k = exp_kind(c);
            x = (c == 4'h8 || c == 4'h9);
            m = (k == 2'h0 && c < 4'hE);
            exp_mem += int'(m);
            exp_fence += int'(k == 2'h0 && c >= 4'hE);
            check("trap_valid", trap_v, k != 2'h0);
            check("trap_kind", trap_k, k);
            check("mem_valid", mem_v, m);
            check("fence1_valid", f1_v, k == 2'h0 && c == 4'hE);
            check("fence2_valid", f2_v, k == 2'h0 && c == 4'hF);
            if (m)
            begin
                check("mem_write", mem_w, c >= 4'hA);
                check("mem_size", mem_size, exp_size(c));
                check("mem_unsigned", mem_uns, c inside {4'h2, 4'h4, 4'h8});
                check("mem_addr", mem_addr, s1v);
                check("mem_ctx", {mem_virt, mem_two, mem_sua}, {2'h3, vs_sua});
                check("mem_priv", mem_gs, sel);
                check("mem_mxr", {mem_x1, mem_x2}, {hs_mxr | vs_mxr, hs_mxr});
                check("mem_exec", {need_x, fin_xr}, {x, x});
                check("access_fault", fault, x && pmp);
            end
            if (f1_v)
            begin
                check("f1_scope", f1_scope, {!s1z, !s2z});
                check("f1_addr", f1_addr, s1z ? 32'h0 : s1v);
                check("f1_sid", f1_sid, s2z ? 6'h0 : s2v[SL-1:0]);
                check("f1_vmid", {f1_all, f1_vmid}, {1'b0, vmid});
            end
            if (f2_v)
            begin
                check("f2_scope", f2_scope, {!s1z, !s2z});
                check("f2_gpa", f2_gpa, s1z ? 34'h0 : {s1v, 2'h0});
                check("f2_vmid", f2_vmid, s2z ? 5'h0 : s2v[VL-1:0]);
            end
        end
        @(posedge clk);
        #1 check("model_mem", n_mem, exp_mem);
        check("model_fence", n_fence, exp_fence);
        $display("test sweep done");
        {priv, virt, op_code} = {2'h3, 1'b0, 4'h1};
        op_valid = 1'b1;
        reset_n = 1'b0;
        @(posedge clk);
        #1 op_valid = 1'b0;
        check("mem_valid_in_reset", {mem_v, trap_v, f1_v, f2_v}, 4'h0);
        reset_n = 1'b1;
        issue(4'h1);
        check("mem_valid_after_reset", mem_v, 1'b1);
        $display("test reset done");
        wrap_up();
    end
endmodule
